// File: reset_and_stop_recovery.sv
// Notes on behaviour
// - A low of three cycles on the reset pin may start a reset, four always do.
// - The device stays in reset while the reset pin is held low.
// - A long external reset ends on the third clock edge after the pin rises.
// - After a pin-caused reset the external flag of the cause register is 1.
// - During the reset delay of every reset, or when port logic asks while running, the pin drives low.
// - Internal resets drive the pin low until the reset delay has run out.
// - The debugger request bit starts a power-on type reset, debugger kept.
// - The request bit clears during that reset; power-on flag set after it.
// - Stop mode is entered when the processor executes the stop instruction.
// - Stop recovery holds the processor 66 or 5000 oscillator cycles.
// - Stop recovery changes only the cause and oscillator control registers.
// - After stop recovery the internal oscillator is enabled and selected.
// - On reset ports A, B and C become inputs with alternate functions off.
// - At power-up port D bit 0 takes its reset pin alternate function.
`timescale 1ns/1ps
`default_nettype none
module reset_and_stop_recovery #(
    parameter int unsigned STOP_HOLD_LONG = rst_pkg::HOLD_XTAL_ON
) (
    // Clock and power-on reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Open-drain reset pin
    input wire logic reset_pin_in,
    output logic reset_pin_out,
    output logic reset_pin_oe,
    input wire logic gpio_drive_low,
    // Internal reset sources
    input wire logic voltage_brownout_event,
    input wire logic watchdog_timer_event,
    input wire logic dbg_reset_set,
    output logic dbg_reset_request,
    // Stop mode
    input wire logic stop_instr,
    input wire logic stop_wake,
    input wire logic ipo_tick,
    output logic stop_mode,
    // Reset outputs
    output logic system_reset,
    output logic cpu_reset,
    // Cause and oscillator control registers
    output logic [7:0] reset_cause_register,
    input wire logic osc_we,
    input wire logic [7:0] osc_wdata,
    output logic [7:0] oscillator_control_register,
    // Port configuration
    input wire logic port_cfg_we,
    input wire logic [rst_pkg::PORT_BITS-1:0] port_input_wdata,
    input wire logic [rst_pkg::PORT_BITS-1:0] port_altfn_wdata,
    input wire logic port_d0_alt_wdata,
    output logic [rst_pkg::PORT_BITS-1:0] port_input,
    output logic [rst_pkg::PORT_BITS-1:0] port_altfn,
    output logic port_d0_reset_alt
);
    import rst_pkg::*;
    recov_if rif();
    hold_timer #(
        .SHORT_CNT(HOLD_XTAL_OFF),
        .LONG_CNT(STOP_HOLD_LONG)
    ) u_hold (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .rif(rif)
    );

    // Pin synchroniser and three-sample qualifier
    logic pin_s1;
    logic pin_s2;
    logic [1:0] pin_prev;
    logic [1:0] own_drive;
    logic pin_low;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pin_s1 <= 1'b1;
            pin_s2 <= 1'b1;
            pin_prev <= 2'h3;
            own_drive <= 2'h3;
        end else begin
            pin_s1 <= reset_pin_in;
            pin_s2 <= pin_s1;
            pin_prev <= {pin_prev[0], pin_s2};
            own_drive <= {own_drive[0], reset_pin_oe};
        end
    end
    // Own drive still in the chain is not an external reset
    assign pin_low = !pin_s2 && (pin_prev == 2'h0)
        && !reset_pin_oe && (own_drive == 2'h0);
    rst_state_t state;
    rst_state_t next_state;
    logic [DELAY_W-1:0] dly;
    logic [DELAY_W-1:0] next_dly;
    logic [7:0] pend_cause;
    logic [7:0] next_pend_cause;
    logic [7:0] next_cause;
    logic [7:0] next_osc;
    logic next_dbg;
    logic next_start;
    logic start;
    logic next_oe;
    logic [PORT_BITS-1:0] next_pin;
    logic [PORT_BITS-1:0] next_alt;
    logic next_d0;
    logic reset_req;
    logic [7:0] req_cause;
    logic in_reset;
    assign in_reset = (state == ST_HOLD) || (state == ST_WAIT_PIN);
    assign rif.start = start;
    assign rif.long_hold = oscillator_control_register[OSC_XTAL_EN];
    assign rif.ipo_tick = ipo_tick;
    always_comb begin
        reset_req = 1'b1;
        req_cause = 8'h00;
        if (voltage_brownout_event) begin
            req_cause = cause_of(CAUSE_VBO);
        end else if (watchdog_timer_event) begin
            req_cause = cause_of(CAUSE_WDT);
        end else if (dbg_reset_request) begin
            req_cause = cause_of(CAUSE_POR);
        end else if (pin_low && !gpio_drive_low) begin
            req_cause = cause_of(CAUSE_EXT);
        end else begin
            reset_req = 1'b0;
        end
    end

    always_comb begin
        next_state = state;
        next_dly = dly;
        next_pend_cause = pend_cause;
        next_cause = reset_cause_register;
        next_osc = oscillator_control_register;
        next_dbg = dbg_reset_request || dbg_reset_set;
        next_start = 1'b0;
        next_pin = port_input;
        next_alt = port_altfn;
        next_d0 = port_d0_reset_alt;
        if (!in_reset && reset_req) begin
            next_state = ST_HOLD;
            next_dly = DELAY_W'(RESET_DELAY_CYC);
            next_pend_cause = req_cause;
        end else begin
            case (state)
                ST_RUN: begin
                    if (stop_instr) begin
                        next_state = ST_STOPPED;
                    end
                    if (osc_we) begin
                        next_osc = osc_wdata;
                    end
                    if (port_cfg_we) begin
                        next_pin = port_input_wdata;
                        next_alt = port_altfn_wdata;
                        next_d0 = port_d0_alt_wdata;
                    end
                end
                ST_HOLD: begin
                    next_dbg = dbg_reset_set;
                    next_pin = '1;
                    next_alt = '0;
                    if (dly == '0) begin
                        next_state = ST_WAIT_PIN;
                    end else begin
                        next_dly = dly - DELAY_W'(1);
                    end
                end
                ST_WAIT_PIN: begin
                    if (pin_s2) begin
                        next_state = ST_RUN;
                        next_cause = pend_cause;
                    end
                end
                ST_STOPPED: begin
                    if (stop_wake) begin
                        next_state = ST_RECOVER;
                        next_start = 1'b1;
                    end
                end
                ST_RECOVER: begin
                    if (!start && !rif.busy) begin
                        next_state = ST_RUN;
                        next_cause = cause_of(CAUSE_STOP);
                        next_osc[OSC_IPO_EN] = 1'b1;
                        next_osc[OSC_SEL_LSB +: 2] = OSC_SEL_IPO;
                    end
                end
                default: begin
                    next_state = ST_HOLD;
                end
            endcase
        end
        next_oe = (next_state == ST_HOLD)
            || (next_state == ST_RUN && gpio_drive_low);
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state <= ST_HOLD;
            dly <= DELAY_W'(RESET_DELAY_CYC);
            pend_cause <= CAUSE_RESET;
            reset_cause_register <= CAUSE_RESET;
            oscillator_control_register <= OSC_RESET;
            dbg_reset_request <= 1'b0;
            start <= 1'b0;
            reset_pin_oe <= 1'b1;
            reset_pin_out <= 1'b0;
            system_reset <= 1'b1;
            cpu_reset <= 1'b1;
            stop_mode <= 1'b0;
            port_input <= '1;
            port_altfn <= '0;
            port_d0_reset_alt <= 1'b1;
        end else begin
            state <= next_state;
            dly <= next_dly;
            pend_cause <= next_pend_cause;
            reset_cause_register <= next_cause;
            oscillator_control_register <= next_osc;
            dbg_reset_request <= next_dbg;
            start <= next_start;
            reset_pin_oe <= next_oe;
            reset_pin_out <= 1'b0;
            system_reset <= (next_state == ST_HOLD)
                || (next_state == ST_WAIT_PIN);
            cpu_reset <= (next_state == ST_HOLD)
                || (next_state == ST_WAIT_PIN)
                || (next_state == ST_RECOVER);
            stop_mode <= (next_state == ST_STOPPED);
            port_input <= next_pin;
            port_altfn <= next_alt;
            port_d0_reset_alt <= next_d0;
        end
    end

    // Oscillator ticks seen while the recovery hold runs
    logic [HOLD_W-1:0] tick_seen;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            tick_seen <= '0;
        end else if (start) begin
            tick_seen <= '0;
        end else if (rif.busy && ipo_tick) begin
            tick_seen <= tick_seen + HOLD_W'(1);
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    pin_four_low_a: assert property (
        (!system_reset && !gpio_drive_low && !reset_pin_in)[*4]
        |-> ##[0:2] system_reset)
        else $error("four low samples did not start a reset");
    hold_while_low_a: assert property (
        system_reset && !reset_pin_in |=> system_reset)
        else $error("reset released while pin low");
    exit_after_rise_a: assert property (
        $fell(system_reset) |-> $past(reset_pin_in, 3))
        else $error("reset left without pin high");
    cause_single_a: assert property (
        $fell(system_reset) |-> reset_cause_register == $past(pend_cause)
        && $onehot(reset_cause_register))
        else $error("cause register not single latest source");
    ext_flag_set_a: assert property (
        $fell(system_reset) && $past(pend_cause[CAUSE_EXT])
        |-> reset_cause_register[CAUSE_EXT])
        else $error("external flag missing");
    pin_drive_hold_a: assert property (
        state == ST_HOLD |-> reset_pin_oe && !reset_pin_out)
        else $error("pin not driven during reset delay");
    dbg_starts_reset_a: assert property (
        dbg_reset_request && !system_reset && state == ST_RUN
        |-> ##1 system_reset)
        else $error("debugger request did not reset");
    dbg_self_clear_a: assert property (
        state == ST_HOLD && !dbg_reset_set |=> !dbg_reset_request)
        else $error("debugger request not cleared");
    stop_enter_a: assert property (
        state == ST_RUN && stop_instr && !reset_req |=> stop_mode)
        else $error("stop mode not entered");
    hold_length_a: assert property (
        state == ST_RECOVER && next_state == ST_RUN
        |-> tick_seen == (oscillator_control_register[OSC_XTAL_EN]
        ? HOLD_W'(STOP_HOLD_LONG) : HOLD_W'(HOLD_XTAL_OFF)))
        else $error("recovery hold length wrong");
    ports_kept_a: assert property (
        state == ST_RECOVER |=> $stable(port_input) && $stable(port_altfn))
        else $error("recovery changed port setup");
    ipo_selected_a: assert property (
        $past(state) == ST_RECOVER && state == ST_RUN
        |-> oscillator_control_register[OSC_IPO_EN]
        && oscillator_control_register[OSC_SEL_LSB +: 2] == OSC_SEL_IPO)
        else $error("oscillator not reset to internal source");
    ports_input_a: assert property (
        state == ST_HOLD |=> port_input == '1 && port_altfn == '0)
        else $error("ports not inputs after reset");
endmodule
`default_nettype wire

// File: rst_pkg.sv
package rst_pkg;
    // System reset timing, in sys_clk cycles
    localparam int unsigned RESET_DELAY_CYC = 16;
    localparam int unsigned DELAY_W = 16;
    // Stop recovery hold in internal oscillator cycles
    localparam int unsigned HOLD_XTAL_OFF = 66;
    localparam int unsigned HOLD_XTAL_ON = 5000;
    localparam int unsigned HOLD_W = 13;
    // Reset cause register bit positions
    localparam int unsigned CAUSE_POR = 7;
    localparam int unsigned CAUSE_STOP = 6;
    localparam int unsigned CAUSE_WDT = 5;
    localparam int unsigned CAUSE_EXT = 4;
    localparam int unsigned CAUSE_VBO = 3;
    localparam logic [7:0] CAUSE_RESET = 8'h80;
    // Oscillator control register layout
    localparam int unsigned OSC_IPO_EN = 7;
    localparam int unsigned OSC_XTAL_EN = 6;
    localparam int unsigned OSC_SEL_LSB = 0;
    localparam logic [1:0] OSC_SEL_IPO = 2'h0;
    localparam logic [7:0] OSC_RESET = 8'h80;
    // Ports A, B and C, eight pins each
    localparam int unsigned PORT_BITS = 24;

    typedef enum logic [2:0] {
        ST_RUN = 3'b000,
        ST_HOLD = 3'b001,
        ST_WAIT_PIN = 3'b010,
        ST_STOPPED = 3'b011,
        ST_RECOVER = 3'b100
    } rst_state_t;

    function automatic logic [7:0] cause_of(input int unsigned pos);
        cause_of = 8'h00;
        cause_of[pos[2:0]] = 1'b1;
    endfunction
endpackage

// File: recov_if.sv
`timescale 1ns/1ps
`default_nettype none
interface recov_if;
    logic start;
    logic long_hold;
    logic ipo_tick;
    logic busy;
    modport timer (input start, input long_hold, input ipo_tick,
        output busy);
    modport ctrl (output start, output long_hold, output ipo_tick,
        input busy);
endinterface
`default_nettype wire

// File: hold_timer.sv
`timescale 1ns/1ps
`default_nettype none
module hold_timer #(
    parameter int unsigned SHORT_CNT = rst_pkg::HOLD_XTAL_OFF,
    parameter int unsigned LONG_CNT = rst_pkg::HOLD_XTAL_ON
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Control side
    recov_if.timer rif
);
    import rst_pkg::*;

    logic [HOLD_W-1:0] cnt;
    logic [HOLD_W-1:0] next_cnt;
    logic busy;
    logic next_busy;

    always_comb begin
        next_cnt = cnt;
        next_busy = busy;
        if (rif.start) begin
            next_cnt = rif.long_hold ? HOLD_W'(LONG_CNT) : HOLD_W'(SHORT_CNT);
            next_busy = 1'b1;
        end else if (busy && rif.ipo_tick) begin
            next_cnt = cnt - HOLD_W'(1);
            if (cnt == HOLD_W'(1)) begin
                next_busy = 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cnt <= '0;
            busy <= 1'b0;
        end else begin
            cnt <= next_cnt;
            busy <= next_busy;
        end
    end

    assign rif.busy = busy;
endmodule
`default_nettype wire

// File: board_reset.sv
`timescale 1ns/1ps
`default_nettype none
module board_reset (
    // Board push button
    input wire logic press,
    // Device open-drain drive
    input wire logic dev_oe,
    input wire logic dev_out,
    // Wired reset line
    output logic pin
);
    // Pull-up on the line; any driver wins low
    assign pin = (press || (dev_oe && !dev_out)) ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

// File: reset_and_stop_recovery_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin errors++; \
    $display("ERROR at %0t: got %0h expected %0h", $time, a, b); end end
module reset_and_stop_recovery_bench;
    import rst_pkg::*;
    localparam int unsigned LONG_HOLD = 20;
    logic sys_clk, rstn, press, pin, pin_out, pin_oe, gpio_low;
    logic bo_ev, wd_ev, dbg_set, dbg_req, stop_instr, stop_wake;
    logic ipo_tick = 1'b0;
    logic stop_mode, system_reset, cpu_reset, osc_we, port_we, d0_w, d0_alt;
    logic [7:0] cause, osc_wdata, osc;
    logic [PORT_BITS-1:0] in_w, alt_w, port_in, port_alt;
    logic counting;
    int errors = 0;
    int check_count = 0;
    int ticks = 0;

    board_reset board (.press(press), .dev_oe(pin_oe), .dev_out(pin_out),
        .pin(pin));
    reset_and_stop_recovery #(.STOP_HOLD_LONG(LONG_HOLD)) uut (
        .sys_clk(sys_clk), .rstn(rstn), .reset_pin_in(pin),
        .reset_pin_out(pin_out), .reset_pin_oe(pin_oe),
        .gpio_drive_low(gpio_low), .voltage_brownout_event(bo_ev),
        .watchdog_timer_event(wd_ev), .dbg_reset_set(dbg_set),
        .dbg_reset_request(dbg_req), .stop_instr(stop_instr),
        .stop_wake(stop_wake), .ipo_tick(ipo_tick), .stop_mode(stop_mode),
        .system_reset(system_reset), .cpu_reset(cpu_reset),
        .reset_cause_register(cause), .osc_we(osc_we),
        .osc_wdata(osc_wdata), .oscillator_control_register(osc),
        .port_cfg_we(port_we), .port_input_wdata(in_w),
        .port_altfn_wdata(alt_w), .port_d0_alt_wdata(d0_w),
        .port_input(port_in), .port_altfn(port_alt),
        .port_d0_reset_alt(d0_alt));

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    // Internal oscillator modelled at half the system rate
    always @(negedge sys_clk) ipo_tick <= ~ipo_tick;
    always @(posedge sys_clk) begin
        if (counting !== 1'b1) ticks <= 0;
        else if (ipo_tick === 1'b1) ticks <= ticks + 1;
    end

    task automatic end_sim();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    // Bounded wait on system_reset (sel 0) or cpu_reset (sel 1)
    task automatic wait_for(input int sel, input logic v, input int bound);
        int i;
        for (i = 0; i < bound; i++) begin
            if ((sel == 0 ? system_reset : cpu_reset) === v) return;
            cyc(1);
        end
        errors++;
        $display("ERROR at %0t: wait timed out", $time);
        end_sim();
    endtask
    task automatic pulse_ev(input int which);
        if (which == 0) bo_ev = 1'b1;
        else if (which == 1) wd_ev = 1'b1;
        else dbg_set = 1'b1;
        cyc(1);
        bo_ev = 1'b0;
        wd_ev = 1'b0;
        dbg_set = 1'b0;
    endtask
    task automatic stop_run(input logic [7:0] osc_val, input int exp_n);
        osc_wdata = osc_val;
        osc_we = 1'b1;
        cyc(1);
        osc_we = 1'b0;
        cyc(1);
        `CHK(osc, osc_val)
        stop_instr = 1'b1;
        cyc(1);
        stop_instr = 1'b0;
        cyc(2);
        `CHK(stop_mode, 1'b1)
        cyc(5);
        counting = 1'b1;
        stop_wake = 1'b1;
        cyc(1);
        stop_wake = 1'b0;
        wait_for(1, 1'b1, 4);
        wait_for(1, 1'b0, 3 * exp_n + 20);
        counting = 1'b0;
        `CHK(ticks >= exp_n - 2 && ticks <= exp_n + 2, 1'b1)
        `CHK(cause, cause_of(CAUSE_STOP))
        `CHK(osc[OSC_IPO_EN], 1'b1)
        `CHK(osc[1:0], OSC_SEL_IPO)
        `CHK(port_in, 24'h00A5F0)
        `CHK(port_alt, 24'h0F0F00)
        `CHK(d0_alt, 1'b0)
        `CHK(system_reset, 1'b0)
        $display("test stop recovery %0d done", exp_n);
    endtask

    initial begin
        rstn = 1'b0;
        {press, gpio_low, bo_ev, wd_ev, dbg_set, stop_instr, stop_wake} = '0;
        {osc_we, port_we, d0_w, counting} = '0;
        osc_wdata = 8'h00;
        in_w = 24'h00A5F0;
        alt_w = 24'h0F0F00;
        cyc(12);
        `CHK(cause, CAUSE_RESET)
        `CHK(port_in, 24'hFFFFFF)
        `CHK(port_alt, 24'h000000)
        `CHK(d0_alt, 1'b1)
        `CHK(pin_oe, 1'b1)
        rstn = 1'b1;
        wait_for(0, 1'b0, 80);
        $display("test power-on done");
        // Short pin glitch must not reset
        press = 1'b1;
        cyc(2);
        press = 1'b0;
        cyc(8);
        `CHK(system_reset, 1'b0)
        port_we = 1'b1;
        cyc(1);
        port_we = 1'b0;
        cyc(1);
        `CHK(port_alt, 24'h0F0F00)
        // Long pin reset
        press = 1'b1;
        cyc(4);
        wait_for(0, 1'b1, 3);
        `CHK(pin_oe, 1'b1)
        cyc(RESET_DELAY_CYC + 30);
        `CHK(system_reset, 1'b1)
        press = 1'b0;
        wait_for(0, 1'b0, 6);
        `CHK(cause, cause_of(CAUSE_EXT))
        `CHK(port_in, 24'hFFFFFF)
        `CHK(port_alt, 24'h000000)
        $display("test pin reset done");
        // Internal sources drive the pin low
        for (int k = 0; k < 2; k++) begin
            pulse_ev(k);
            wait_for(0, 1'b1, 3);
            `CHK(pin_oe, 1'b1)
            `CHK(pin, 1'b0)
            wait_for(0, 1'b0, 80);
            `CHK(cause, cause_of(k == 0 ? CAUSE_VBO : CAUSE_WDT))
        end
        $display("test internal resets done");
        pulse_ev(2);
        `CHK(dbg_req, 1'b1)
        wait_for(0, 1'b1, 3);
        wait_for(0, 1'b0, 80);
        `CHK(dbg_req, 1'b0)
        `CHK(cause, cause_of(CAUSE_POR))
        $display("test debugger reset done");
        gpio_low = 1'b1;
        cyc(6);
        `CHK(pin_oe, 1'b1)
        `CHK(system_reset, 1'b0)
        gpio_low = 1'b0;
        cyc(8);
        `CHK(system_reset, 1'b0)
        `CHK(cause, cause_of(CAUSE_POR))
        $display("test port drive done");
        port_we = 1'b1;
        cyc(1);
        port_we = 1'b0;
        stop_run(8'hC3, LONG_HOLD);
        stop_run(8'h80, HOLD_XTAL_OFF);
        end_sim();
    end
endmodule
`default_nettype wire
